// ===== verilog/utrc_pkg.sv
/*
 Constants, field positions and state types of the serial core.
 Assumes one 25 MHz clock and a 32-bit APB slave port with 8 address bits.
*/
// How it works
// - Frame: start, data, parity, stop bits
// - Optional MSB-first data order
// - Seven data bits and two stop bits
// - Inverted transmit output option
// - Even parity generation and checking
// - Odd parity generation and checking
// - Zero parity sends 0, never checks
// - No parity bit, no parity error
// - Buffer write starts transmission when enabled
// - Buffer moves to shift register, bits appended
// - Completion request right after last stop
// - Transmitter idles until next buffer write
// - Buffer writable once shifting has begun
// - Status bit 1 shows buffer full
// - Status bit 0 shows shifting active
// - Flags step 11, 10, 01 continuously
// - Start bit confirmed low after divisor count
// - Stop bit: request, copy unless overrun
// - Parity error reported at frame end
// - Receiver checks exactly one stop bit
// - Reading error status clears all flags
// - Merge bit low: separate error request
package utrc_pkg;

   // ---------------------------------------------
   // Register byte addresses
   // ---------------------------------------------
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CTL = 8'h04;
   localparam logic [7:0] ADDR_DIV = 8'h08;
   localparam logic [7:0] ADDR_TXB = 8'h0c;
   localparam logic [7:0] ADDR_RXB = 8'h10;
   localparam logic [7:0] ADDR_ERR = 8'h14;
   localparam logic [7:0] ADDR_TXST = 8'h18;

   // ---------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------
   localparam int M_POWER = 7;
   localparam int M_TXEN = 6;
   localparam int M_RXEN = 5;
   localparam int M_PSH = 4;
   localparam int M_PSL = 3;
   localparam int M_CL8 = 2;
   localparam int M_SL2 = 1;
   localparam int M_MERGE = 0;
   localparam int C_MSB = 1;
   localparam int C_INV = 0;
   localparam int E_FE = 2;
   localparam int E_PE = 1;
   localparam int E_OVE = 0;
   localparam int S_FULL = 1;
   localparam int S_BUSY = 0;
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] DIV_RST = 8'h10;
   localparam logic [7:0] RXB_RST = 8'hff;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } utrc_rx_type;

endpackage

// ===== verilog/utrc_core.sv
/*
 Asynchronous serial transmitter and receiver with an APB register port.
 Assumes an APB master on CLK and a remote UART on the serial pins;
 the receive pin is asynchronous to CLK.
*/
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module utrc_core import utrc_pkg::*; (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic SERIAL_RX_PIN,
   output logic SERIAL_TX_PIN,
   output logic TX_COMPLETE_IRQ,
   output logic RX_COMPLETE_IRQ,
   output logic RX_ERROR_IRQ
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [1:0] ctl;
      logic [7:0] div;
      logic [7:0] txb;
      logic txb_full;
      logic [11:0] txs;
      logic [3:0] tx_left;
      logic [8:0] tx_cnt;
      logic tx_busy;
      logic tx_pin;
      logic tx_irq;
      logic [2:0] rx_sync;
      logic rxf;
      logic rxf_prev;
      utrc_rx_type rx_st;
      logic [8:0] rx_cnt;
      logic [3:0] rx_idx;
      logic [7:0] rxs;
      logic rx_par;
      logic rx_perr;
      logic [7:0] rxb;
      logic rxb_new;
      logic [2:0] err;
      logic rx_irq;
      logic rxe_irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } utrc_state_type;

   utrc_state_type s_q;
   utrc_state_type s_d;

   // ---------------------------------------------
   // Frame assembly
   // ---------------------------------------------
   // Bit 0 leaves first; unused upper positions are stop level
   function automatic logic [11:0] frame_of(input logic [7:0] d,
                                             input logic [7:0] m,
                                             input logic msb);
      logic [11:0] f;
      logic [7:0] o;
      logic p;
      int pos;
      f = 12'hfff;
      f[0] = 1'b0;
      pos = 1;
      o = d;
      if (msb) begin
         for (int i = 0; i < 8; i++) begin
            o[i] = m[M_CL8] ? d[7 - i] : ((i < 7) ? d[6 - i] : 1'b0);
         end
      end
      for (int i = 0; i < 8; i++) begin
         if (i < 7 || m[M_CL8]) begin
            f[pos] = o[i];
            pos = pos + 1;
         end
      end
      p = ^(m[M_CL8] ? d : {1'b0, d[6:0]});
      case ({m[M_PSH], m[M_PSL]})
         PAR_EVEN: begin
            f[pos] = p;
            pos = pos + 1;
         end
         PAR_ODD: begin
            f[pos] = ~p;
            pos = pos + 1;
         end
         PAR_ZERO: begin
            f[pos] = 1'b0;
            pos = pos + 1;
         end
         default: begin
            f[pos] = 1'b1;
         end
      endcase
      return f;
   endfunction

   // Start, data, parity if any, one or two stops
   function automatic logic [3:0] bits_of(input logic [7:0] m);
      return 4'd9 + {3'b000, m[M_SL2]} + {3'b000, m[M_CL8]}
             + {3'b000, (m[M_PSH] | m[M_PSL])};
   endfunction

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   logic tx_en;
   logic rx_en;
   logic setup;
   logic acc;
   logic [8:0] half_last;
   logic [8:0] full_last;
   logic [1:0] ps;
   logic [7:0] rxd;
   logic [2:0] new_err;

   always_comb begin
      s_d = s_q;
      new_err = 3'h0;
      rxd = 8'h00;
      tx_en = s_q.mode[M_POWER] & s_q.mode[M_TXEN];
      rx_en = s_q.mode[M_POWER] & s_q.mode[M_RXEN];
      ps = {s_q.mode[M_PSH], s_q.mode[M_PSL]};
      half_last = {1'b0, s_q.div} - 9'd1;
      full_last = {s_q.div, 1'b0} - 9'd1;
      setup = PSEL & ~PENABLE;
      acc = PSEL & PENABLE & s_q.pready;
      s_d.tx_irq = 1'b0;
      s_d.rx_irq = 1'b0;
      s_d.rxe_irq = 1'b0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;

      // APB: answer is set up during the setup cycle, zero wait states
      if (setup) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h0;
         if (PADDR == ADDR_MODE) begin
            s_d.prdata[7:0] = s_q.mode;
         end else if (PADDR == ADDR_CTL) begin
            s_d.prdata[1:0] = s_q.ctl;
         end else if (PADDR == ADDR_DIV) begin
            s_d.prdata[7:0] = s_q.div;
         end else if (PADDR == ADDR_TXB) begin
            s_d.prdata[7:0] = s_q.txb;
         end else if (PADDR == ADDR_RXB) begin
            s_d.prdata[7:0] = s_q.rxb;
         end else if (PADDR == ADDR_ERR) begin
            s_d.prdata[2:0] = s_q.err;
         end else if (PADDR == ADDR_TXST) begin
            s_d.prdata[S_FULL] = s_q.txb_full;
            s_d.prdata[S_BUSY] = s_q.tx_busy;
         end else begin
            s_d.pslverr = 1'b1;
         end
      end
      if (acc && PWRITE) begin
         if (PADDR == ADDR_MODE) begin
            s_d.mode = PWDATA[7:0];
         end else if (PADDR == ADDR_CTL) begin
            s_d.ctl = PWDATA[1:0];
         end else if (PADDR == ADDR_DIV) begin
            s_d.div = PWDATA[7:0];
         end else if (PADDR == ADDR_TXB && tx_en) begin
            s_d.txb = PWDATA[7:0];
            s_d.txb_full = 1'b1;
         end
      end else if (acc) begin
         if (PADDR == ADDR_ERR) begin
            s_d.err = 3'h0;
         end else if (PADDR == ADDR_RXB) begin
            s_d.rxb_new = 1'b0;
         end
      end

      // ---------------------------------------------
      // Transmitter
      // ---------------------------------------------
      if (!tx_en) begin
         s_d.txb_full = 1'b0;
         s_d.tx_busy = 1'b0;
         s_d.tx_cnt = 9'h0;
      end else if (s_q.tx_busy) begin
         if (s_q.tx_cnt == full_last) begin
            s_d.tx_cnt = 9'h0;
            if (s_q.tx_left == 4'd1) begin
               s_d.tx_busy = 1'b0;
               s_d.tx_irq = 1'b1;
            end else begin
               s_d.txs = {1'b1, s_q.txs[11:1]};
               s_d.tx_left = s_q.tx_left - 4'd1;
            end
         end else begin
            s_d.tx_cnt = s_q.tx_cnt + 9'd1;
         end
      end else if (s_q.txb_full) begin
         // Frees the buffer as shifting begins
         s_d.txs = frame_of(s_q.txb, s_q.mode, s_q.ctl[C_MSB]);
         s_d.tx_left = bits_of(s_q.mode);
         s_d.txb_full = 1'b0;
         s_d.tx_busy = 1'b1;
         s_d.tx_cnt = 9'h0;
      end
      s_d.tx_pin = (s_d.tx_busy ? s_d.txs[0] : 1'b1) ^ s_q.ctl[C_INV];

      // ---------------------------------------------
      // Receiver
      // ---------------------------------------------
      s_d.rx_sync = {s_q.rx_sync[1:0], SERIAL_RX_PIN};
      if (s_q.rx_sync[1] == s_q.rx_sync[2]) begin
         s_d.rxf = s_q.rx_sync[2];
      end
      s_d.rxf_prev = s_q.rxf;
      if (!rx_en) begin
         s_d.rx_st = RX_IDLE;
         s_d.rx_cnt = 9'h0;
      end else begin
         case (s_q.rx_st)
            RX_IDLE: begin
               s_d.rx_cnt = 9'h0;
               if (s_q.rxf_prev && !s_q.rxf) begin
                  s_d.rx_st = RX_START;
               end
            end
            RX_START: begin
               s_d.rx_cnt = s_q.rx_cnt + 9'd1;
               if (s_q.rx_cnt == half_last) begin
                  s_d.rx_cnt = 9'h0;
                  s_d.rx_idx = 4'h0;
                  s_d.rx_par = 1'b0;
                  s_d.rx_perr = 1'b0;
                  s_d.rx_st = s_q.rxf ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               s_d.rx_cnt = s_q.rx_cnt + 9'd1;
               if (s_q.rx_cnt == full_last) begin
                  s_d.rx_cnt = 9'h0;
                  s_d.rx_idx = s_q.rx_idx + 4'd1;
                  s_d.rx_par = s_q.rx_par ^ s_q.rxf;
                  if (s_q.ctl[C_MSB]) begin
                     s_d.rxs = {s_q.rxs[6:0], s_q.rxf};
                  end else begin
                     s_d.rxs = {s_q.rxf, s_q.rxs[7:1]};
                  end
                  if (s_q.rx_idx == (s_q.mode[M_CL8] ? 4'd7 : 4'd6)) begin
                     s_d.rx_st = (ps == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
            end
            RX_PAR: begin
               s_d.rx_cnt = s_q.rx_cnt + 9'd1;
               if (s_q.rx_cnt == full_last) begin
                  s_d.rx_cnt = 9'h0;
                  // Error is only noted here; reception runs on
                  if (ps == PAR_EVEN) begin
                     s_d.rx_perr = s_q.rx_par ^ s_q.rxf;
                  end else if (ps == PAR_ODD) begin
                     s_d.rx_perr = ~(s_q.rx_par ^ s_q.rxf);
                  end else begin
                     s_d.rx_perr = 1'b0;
                  end
                  s_d.rx_st = RX_STOP;
               end
            end
            RX_STOP: begin
               s_d.rx_cnt = s_q.rx_cnt + 9'd1;
               if (s_q.rx_cnt == full_last) begin
                  // A second stop bit is never looked at
                  s_d.rx_cnt = 9'h0;
                  s_d.rx_st = RX_IDLE;
                  if (s_q.mode[M_CL8]) begin
                     rxd = s_q.rxs;
                  end else if (s_q.ctl[C_MSB]) begin
                     rxd = {1'b0, s_q.rxs[6:0]};
                  end else begin
                     rxd = {1'b0, s_q.rxs[7:1]};
                  end
                  new_err[E_FE] = ~s_q.rxf;
                  new_err[E_PE] = s_q.rx_perr;
                  new_err[E_OVE] = s_q.rxb_new;
                  if (!s_q.rxb_new) begin
                     s_d.rxb = rxd;
                     s_d.rxb_new = 1'b1;
                  end
                  // Set wins over a same-cycle read clear
                  s_d.err = s_d.err | new_err;
                  if ((|new_err) && !s_q.mode[M_MERGE]) begin
                     s_d.rxe_irq = 1'b1;
                  end else begin
                     s_d.rx_irq = 1'b1;
                  end
               end
            end
            default: begin
               s_d.rx_st = RX_IDLE;
            end
         endcase
      end

      // Clock gate off clears status and receive data
      if (!s_q.mode[M_POWER]) begin
         s_d.err = 3'h0;
         s_d.rxb = RXB_RST;
         s_d.rxb_new = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         s_q <= '0;
         s_q.mode <= MODE_RST;
         s_q.div <= DIV_RST;
         s_q.rxb <= RXB_RST;
         s_q.txs <= 12'hfff;
         s_q.tx_pin <= 1'b1;
         s_q.rx_sync <= 3'h7;
         s_q.rxf <= 1'b1;
         s_q.rxf_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign SERIAL_TX_PIN = s_q.tx_pin;
   assign TX_COMPLETE_IRQ = s_q.tx_irq;
   assign RX_COMPLETE_IRQ = s_q.rx_irq;
   assign RX_ERROR_IRQ = s_q.rxe_irq;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_load;
      !s_q.tx_busy && s_q.txb_full && tx_en;
   endsequence

   a_tx_load: assert property (s_load |=>
                               s_q.tx_busy && (SERIAL_TX_PIN == s_q.ctl[C_INV]))
      else $error("buffer not moved to shifter with start bit");
   a_tx_done: assert property (TX_COMPLETE_IRQ |->
                               $past(s_q.tx_busy) && !s_q.tx_busy)
      else $error("completion request not at frame end");
   // The pin follows a control write one cycle late
   a_tx_idle: assert property (!s_q.tx_busy |->
                               SERIAL_TX_PIN == ~$past(s_q.ctl[C_INV]))
      else $error("idle line level wrong");
   a_no_both: assert property (s_load |=> !s_q.txb_full ##1 s_q.tx_cnt == 9'd1)
      else $error("buffer not freed when shifting began");
   a_start_low: assert property (s_q.rx_st == RX_START && s_d.rx_st == RX_DATA
                                 |-> !s_q.rxf)
      else $error("start accepted on high level");
   a_perr_mode: assert property ($rose(s_q.err[E_PE]) |-> ps[1])
      else $error("parity error without checking mode");
   a_err_clear: assert property (acc && !PWRITE && PADDR == ADDR_ERR && !(|new_err)
                                 |=> s_q.err == 3'h0)
      else $error("error status not cleared by read");
   a_irq_split: assert property (RX_ERROR_IRQ |-> !s_q.mode[M_MERGE] && !RX_COMPLETE_IRQ
                                 && s_q.err != 3'h0)
      else $error("error request routing wrong");
   a_ove_keep: assert property (new_err[E_OVE] |=> $stable(s_q.rxb))
      else $error("receive buffer overwritten on overrun");

endmodule

// ===== bench/utrc_remote.sv
/*
 Behavioural remote UART on the serial pins: sends frames, glitches, captures frames.
 Assumes the core's bit time equals BIT_CYC cycles of clk.
*/
`timescale 1ns/1ns
module utrc_remote #(
   parameter int BIT_CYC = 8
) (
   input wire logic clk,
   input wire logic tx_line,
   output logic rx_line
);
   // Line idles at the mark level between frames
   initial rx_line = 1'b1;

   // ---------------------------------------------
   // Transmit towards the core, bit 0 first
   // ---------------------------------------------
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_line <= bits[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
      @(posedge clk);
      rx_line <= 1'b1;
   endtask

   // Short low pulse that must not pass as a start bit
   task automatic glitch(input int c);
      @(posedge clk);
      rx_line <= 1'b0;
      repeat (c) @(posedge clk);
      rx_line <= 1'b1;
   endtask

   // ---------------------------------------------
   // Capture from the core, sampling mid-bit
   // ---------------------------------------------
   task automatic capture(input logic idle, input int n, output logic [11:0] bits);
      int t;
      bits = 12'hfff;
      t = 0;
      while (tx_line === idle && t < 2000) begin
         @(posedge clk);
         t++;
      end
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = tx_line;
         if (i < n - 1) repeat (BIT_CYC) @(posedge clk);
      end
   endtask
endmodule

// ===== bench/tb_top.sv
/*
 Self-checking bench of the serial core: APB master tasks and scenario tasks.
 Assumes divisor 4, so one bit is 8 clock cycles, and a remote model on the pins.
*/
`timescale 1ns/1ns
module tb_top import utrc_pkg::*; ;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic rx_pin, tx_pin, tx_irq, rxc_irq, rxe_irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int error_cnt, checks;

   utrc_core u_utrc_core (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SERIAL_RX_PIN(rx_pin), .SERIAL_TX_PIN(tx_pin),
      .TX_COMPLETE_IRQ(tx_irq), .RX_COMPLETE_IRQ(rxc_irq), .RX_ERROR_IRQ(rxe_irq));
   utrc_remote #(.BIT_CYC(8)) u_utrc_remote (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ---------------------------------------------
   // Common tasks
   // ---------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdreg(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 8'h00, r, e);
   endtask

   // Expected frame, bit 0 first on the wire, idle-level stops
   function automatic logic [11:0] frame(input logic [7:0] m, input logic msb,
                                         input logic [7:0] d, output int n);
      int nd;
      logic p;
      logic [11:0] f;
      nd = m[M_CL8] ? 8 : 7;
      p = ^(m[M_CL8] ? d : {1'b0, d[6:0]});
      f = 12'hfff;
      f[0] = 1'b0;
      n = 1;
      for (int i = 0; i < nd; i++) begin
         f[n] = msb ? d[nd - 1 - i] : d[i];
         n++;
      end
      if (m[M_PSH:M_PSL] != PAR_NONE) begin
         f[n] = (m[M_PSH:M_PSL] == PAR_EVEN) ? p : (m[M_PSH:M_PSL] == PAR_ODD) ? ~p : 1'b0;
         n++;
      end
      n = n + 1 + int'(m[M_SL2]);
      return f;
   endfunction

   task automatic rx_frame(input logic [11:0] f, input int n, output logic c, output logic e);
      c = 1'b0;
      e = 1'b0;
      fork
         u_utrc_remote.send(f, n);
         for (int i = 0; i < (n + 4) * 8; i++) begin
            @(posedge clk);
            if (rxc_irq === 1'b1) c = 1'b1;
            if (rxe_irq === 1'b1) e = 1'b1;
         end
      join
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      logic [7:0] ad[5] = '{ADDR_MODE, ADDR_DIV, ADDR_RXB, ADDR_ERR, ADDR_TXST};
      logic [7:0] ex[5] = '{MODE_RST, DIV_RST, RXB_RST, 8'h00, 8'h00};
      logic [31:0] r;
      logic e;
      for (int k = 0; k < 5; k++) begin
         rdreg(ad[k], r);
         chk("reset value", {24'h0, ex[k]}, r);
      end
      apb(1'b0, 8'h1c, 8'h00, r, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      wr(ADDR_TXST, 8'hff);
      wr(ADDR_TXB, 8'h55);
      rdreg(ADDR_TXST, r);
      chk("status read-only, tx off", 32'h0, r);
      chk("tx pin idle", 32'h1, {31'h0, tx_pin});
      $display("test reset done");
   endtask

   task automatic t_tx;
      logic [7:0] md[6] = '{8'hfc, 8'hfc, 8'hfc, 8'hf2, 8'he4, 8'hec};
      logic [1:0] ct[6] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
      logic [7:0] dt[6] = '{8'h55, 8'h55, 8'h55, 8'h36, 8'h87, 8'h5a};
      logic [11:0] f, got, msk;
      logic [31:0] r;
      int n;
      logic irq;
      for (int k = 0; k < 6; k++) begin
         wr(ADDR_MODE, md[k]);
         wr(ADDR_CTL, {6'h0, ct[k]});
         // Also lets the line settle at a new idle level before capture
         rdreg(ADDR_TXST, r);
         chk("status clear before write", 32'h0, r);
         f = frame(md[k], ct[k][1], dt[k], n);
         msk = 12'hfff >> (12 - n);
         fork
            u_utrc_remote.capture(~ct[k][0], n, got);
            wr(ADDR_TXB, dt[k]);
         join
         f = (f ^ {12{ct[k][0]}}) & msk;
         got = got & msk;
         chk("tx frame", {20'h0, f}, {20'h0, got});
         // Slot after the data: parity; without parity, the last data bit
         n = n - 2 - int'(md[k][M_SL2]);
         chk("tx parity", {31'h0, f[n]}, {31'h0, got[n]});
         irq = 1'b0;
         repeat (24) begin
            @(posedge clk);
            if (tx_irq === 1'b1) irq = 1'b1;
         end
         chk("tx done irq", 32'h1, {31'h0, irq});
         chk("tx idle level", {31'h0, ~ct[k][0]}, {31'h0, tx_pin});
      end
      $display("test tx frames done");
   endtask

   task automatic t_cont;
      logic [31:0] r;
      int t;
      wr(ADDR_TXB, 8'h11);
      rdreg(ADDR_TXST, r);
      chk("status after load", 32'h1, r);
      wr(ADDR_TXB, 8'h22);
      rdreg(ADDR_TXST, r);
      chk("status both busy", 32'h3, r);
      t = 0;
      do begin
         rdreg(ADDR_TXST, r);
         t++;
      end while (r[S_FULL] === 1'b1 && t < 100);
      chk("status second loaded", 32'h1, r);
      t = 0;
      do begin
         rdreg(ADDR_TXST, r);
         t++;
      end while (r !== 32'h0 && t < 100);
      chk("status idle", 32'h0, r);
      $display("test continuous done");
   endtask

   task automatic t_rx;
      logic c, e;
      logic [31:0] r;
      logic [11:0] f;
      int n;
      wr(ADDR_MODE, 8'hfc);
      f = frame(8'hfc, 1'b0, 8'ha5, n);
      rx_frame(f, n, c, e);
      chk("rx irqs good", 32'h2, {30'h0, c, e});
      rdreg(ADDR_ERR, r);
      chk("rx err none", 32'h0, r);
      rdreg(ADDR_RXB, r);
      chk("rx data", 32'ha5, r);
      f[9] = ~f[9];
      rx_frame(f, n, c, e);
      chk("rx irqs parity", 32'h1, {30'h0, c, e});
      rdreg(ADDR_ERR, r);
      chk("rx err parity", 32'h1 << E_PE, r);
      rdreg(ADDR_ERR, r);
      chk("rx err cleared", 32'h0, r);
      rdreg(ADDR_RXB, r);
      chk("rx data after err", 32'ha5, r);
      f = frame(8'hfc, 1'b0, 8'h3c, n);
      rx_frame(f, n, c, e);
      f = frame(8'hfc, 1'b0, 8'hc3, n);
      rx_frame(f, n, c, e);
      chk("rx irq overrun", 32'h1, {31'h0, e});
      rdreg(ADDR_ERR, r);
      chk("rx err overrun", 32'h1 << E_OVE, r);
      rdreg(ADDR_RXB, r);
      chk("rx data kept", 32'h3c, r);
      wr(ADDR_MODE, 8'hfd);
      f = frame(8'hfd, 1'b0, 8'h0f, n);
      f[9] = ~f[9];
      rx_frame(f, n, c, e);
      chk("rx irqs merged", 32'h2, {30'h0, c, e});
      rdreg(ADDR_ERR, r);
      chk("rx err merged", 32'h1 << E_PE, r);
      rdreg(ADDR_RXB, r);
      wr(ADDR_MODE, 8'hec);
      f = frame(8'hec, 1'b0, 8'h81, n);
      f[9] = 1'b1;
      rx_frame(f, n, c, e);
      chk("rx zero parity", 32'h2, {30'h0, c, e});
      rdreg(ADDR_RXB, r);
      chk("rx data zero par", 32'h81, r);
      wr(ADDR_MODE, 8'hf2);
      wr(ADDR_CTL, 8'h02);
      f = frame(8'hf2, 1'b1, 8'h36, n);
      rx_frame(f, n, c, e);
      chk("rx irqs 7-bit msb", 32'h2, {30'h0, c, e});
      rdreg(ADDR_ERR, r);
      chk("rx err 7-bit msb", 32'h0, r);
      rdreg(ADDR_RXB, r);
      chk("rx data 7-bit msb", 32'h36, r);
      c = 1'b0;
      fork
         u_utrc_remote.glitch(3);
         repeat (120) begin
            @(posedge clk);
            if (rxc_irq === 1'b1 || rxe_irq === 1'b1) c = 1'b1;
         end
      join
      chk("rx glitch ignored", 32'h0, {31'h0, c});
      $display("test rx done");
   endtask

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      error_cnt = 0;
      checks = 0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      wr(ADDR_DIV, 8'h04);
      // Power first, enables after
      wr(ADDR_MODE, 8'h80);
      t_tx;
      t_cont;
      t_rx;
      print_verdict;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      print_verdict;
   end
endmodule
